// *** rtl/clock_ctrl_pkg.sv ***
package clock_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CLKSET   = 8'h32;
  localparam logic [7:0] REG_PRESCALE = 8'h33;
  localparam logic [7:0] REG_FTRIM    = 8'h34;
  localparam logic [7:0] REG_STRIM    = 8'h35;
  localparam logic [7:0] REG_TTRIM_A  = 8'h36;
  localparam logic [7:0] REG_TTRIM_B  = 8'h37;
  localparam logic [7:0] REG_FUSE     = 8'h38;
  localparam int SETTLED_BIT = 7;
  localparam int TRIGGER_BIT = 6;
  localparam int CLOCK_OUT_FUSE_BIT   = 5;
  localparam int SUT_BIT     = 4;
  // ----------------------------------------------------------------
  // Source codes and indices
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_EXT  = 4'h0;
  localparam logic [3:0] SRC_FAST = 4'h2;
  localparam logic [3:0] SRC_SLOW = 4'h4;
  localparam int IDX_EXT  = 0;
  localparam int IDX_FAST = 1;
  localparam int IDX_SLOW = 2;
  localparam int IDX_RES  = 3;
  localparam logic [3:0] PS_DIV1 = 4'h0;
  localparam logic [3:0] PS_DIV8 = 4'h3;
  localparam logic [3:0] PS_MAX  = 4'h8;
  // ----------------------------------------------------------------
  // Start-up counts in source clock cycles, reset delay in slow-oscillator ticks
  // ----------------------------------------------------------------
  localparam logic [15:0] CK_PD_SHORT  = 16'h0006;
  localparam logic [15:0] CK_RST_EXT   = 16'h0016;
  localparam logic [15:0] CK_RST_FAST  = 16'h0014;
  localparam logic [15:0] CK_RES_SUT0  = 16'h0112;
  localparam logic [15:0] CK_RES_SUT1  = 16'h0400;
  localparam int XTAL_STARTUP_CK = 16384;
  localparam int RESET_DELAY_MS  = 16;
  localparam int SLOW_OSC_KHZ    = 32;
  localparam int RESET_DELAY_TICKS = RESET_DELAY_MS * SLOW_OSC_KHZ;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] source_select;
    logic       startup_time;
    logic       clock_out;
    logic       div8;
  } fuse_s;
  typedef struct packed {
    logic [7:0] fast;
    logic [7:0] slow;
    logic [7:0] temp_a;
    logic [7:0] temp_b;
  } trim_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;
  typedef enum logic [2:0] {
    ST_RST_DLY = 3'b000,
    ST_RST_CK  = 3'b001,
    ST_RUN     = 3'b010,
    ST_SLEEP   = 3'b011,
    ST_WAKE    = 3'b100
  } state_e;
endpackage

// *** rtl/clock_ctrl.sv ***
// Operation
// [RQ1] Four sources: external, fast, slow, resonator
// [RQ2] Fuses load source select at reset
// [RQ3] Fuses readable only; select via register
// [RQ4] Source switch glitch free
// [RQ5] Wake counts start-up on selected source
// [RQ6] Reset adds slow-oscillator timed delay
// [RQ7] External clock steps only in reset
// [RQ8] Start-up bit picks delay length
// [RQ9] Reset loads fast trim calibration
// [RQ10] Fast trim rewritable any time
// [RQ11] Reset loads both temperature trims
// [RQ12] Reset loads slow trim calibration
// [RQ13] Slow oscillator stays on for watchdog
// [RQ14] Factory fuses: fast, longest, divide eight
// [RQ15] Prescaler divides all system clocks
// [RQ16] Prescale change glitch free, never faster
// [RQ17] Prescale counter on source, unreadable
// [RQ18] New divide after old plus new period
// [RQ19] Clock-out bit drives clock on pin
// [RQ20] Clock-out bit loaded from fuse
// [RQ21] No clock out during reset
// [RQ22] Pin carries divided clock, any source
// [RQ23] Source code map, top bit resonator
// [RQ24] Trigger switches now, else enable only
// [RQ25] Settled flag after start-up count
// [RQ26] Prescale codes 1 to 256, rest reserved
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
module clock_ctrl
  import clock_ctrl_pkg::*;
#(
  parameter int XTAL_CK   = XTAL_STARTUP_CK,
  parameter int RST_TICKS = RESET_DELAY_TICKS
)(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire bus_req_s   bus,
  output logic [7:0]      rdata,
  input  wire fuse_s      fuse,
  input  wire trim_s      factory_trim,
  input  wire logic       ext_clock_in,
  input  wire logic       fast_osc_clk,
  input  wire logic       slow_osc_clk,
  input  wire logic       resonator_in,
  input  wire logic       power_down,
  output trim_s           trim,
  output logic [3:0]      osc_enable,
  output logic            watchdog_tick,
  output logic            sys_clk_div,
  output logic            cpu_run,
  output logic            clock_out_pin,
  output logic            clock_out_active
);
  // Refuse start-up counts that the 16-bit counters cannot hold
  if (XTAL_CK < 1 || XTAL_CK > 65535 || RST_TICKS < 1 || RST_TICKS > 65535)
  begin : g_bad_count
    $error("start-up counts out of range");
  end
  localparam logic [15:0] XTAL_CNT = 16'(XTAL_CK);
  localparam logic [15:0] RST_CNT  = 16'(RST_TICKS);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] src_index(input logic [3:0] code);
    if (code[3])
      return 2'(IDX_RES);
    else if (code == SRC_FAST)
      return 2'(IDX_FAST);
    else if (code == SRC_SLOW)
      return 2'(IDX_SLOW);
    else
      return 2'(IDX_EXT);
  endfunction

  function automatic logic legal_src(input logic [3:0] code);
    return code[3] || code == SRC_EXT || code == SRC_FAST || code == SRC_SLOW;
  endfunction

  function automatic logic [15:0] startup_ck(input logic startup_time_select, input logic [3:0] code,
                                             input logic from_rst);
    if (code[3] && code[0])
      return XTAL_CNT;
    else if (code[3])
      return startup_time_select ? CK_RES_SUT1 : CK_RES_SUT0;
    else if (!from_rst)
      return CK_PD_SHORT;
    else
      return (code == SRC_FAST) ? CK_RST_FAST : CK_RST_EXT;
  endfunction

  // ----------------------------------------------------------------
  // Source synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [3:0] src_meta;
  logic [3:0] src_sync;
  logic [3:0] src_last;
  logic [3:0] src_rise;
  logic [3:0] src_edge;

  // Two stages, then a third stage for edges
  always_ff @(posedge sys_clk)
  begin
    src_meta <= {resonator_in, slow_osc_clk, fast_osc_clk, ext_clock_in}; // see [RQ1]
    src_sync <= src_meta;
    src_last <= src_sync;
  end

  // Per-source edge strobes
  for (genvar g = 0; g < 4; g++)
  begin : g_edge
    assign src_rise[g] = src_sync[g] & ~src_last[g];
    assign src_edge[g] = src_sync[g] ^ src_last[g];
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [3:0] src_sel;
  logic [3:0] src_active;
  logic [3:0] sw_code;
  logic       sw_pend;
  logic       startup_time_select;
  logic       clock_out_enable;
  logic       osc_settled;
  logic [15:0] settle_cnt;
  logic [3:0] ps_sel;
  logic       boundary;
  logic       settle_done;
  logic [3:0] next_src_sel;
  logic [3:0] next_sw_code;
  logic       next_sw_pend;
  logic       next_clock_out_fuse;
  logic       next_settled;
  logic [15:0] next_settle_cnt;
  logic [3:0] next_ps_sel;
  trim_s      next_trim;
  logic [7:0] next_rdata;
  logic       wr_clkset;
  logic       src_write;

  assign wr_clkset   = bus.wr && bus.addr == REG_CLKSET;
  assign src_write   = wr_clkset && legal_src(bus.wdata[3:0]);
  assign settle_done = settle_cnt >= startup_ck(startup_time_select, src_sel, 1'b0);

  // Next register values; a legal source write restarts settling
  always_comb
  begin
    next_src_sel    = src_sel;
    next_sw_code    = sw_code;
    next_sw_pend    = sw_pend && !boundary;
    next_clock_out_fuse      = clock_out_enable;
    next_ps_sel     = ps_sel;
    next_trim       = trim;
    next_settle_cnt = settle_cnt;
    if (!settle_done && src_rise[src_index(src_sel)])
      next_settle_cnt = settle_cnt + 16'h0001;
    if (wr_clkset)
    begin
      next_clock_out_fuse = bus.wdata[CLOCK_OUT_FUSE_BIT]; // see [RQ19]
      if (legal_src(bus.wdata[3:0])) // see [RQ23]
      begin
        next_src_sel    = bus.wdata[3:0]; // see [RQ3]
        next_settle_cnt = 16'h0000;
        if (bus.wdata[TRIGGER_BIT])
        begin
          next_sw_code = bus.wdata[3:0]; // see [RQ24]
          next_sw_pend = 1'b1;
        end
      end
    end
    next_settled = (settle_done || osc_settled) && !src_write; // see [RQ25]
    if (bus.wr && bus.addr == REG_PRESCALE && bus.wdata[3:0] <= PS_MAX)
      next_ps_sel = bus.wdata[3:0]; // see [RQ26]
    if (bus.wr && bus.addr == REG_FTRIM)
      next_trim.fast = bus.wdata; // see [RQ10]
    if (bus.wr && bus.addr == REG_STRIM)
      next_trim.slow = bus.wdata;
    if (bus.wr && bus.addr == REG_TTRIM_A)
      next_trim.temp_a = bus.wdata;
    if (bus.wr && bus.addr == REG_TTRIM_B)
      next_trim.temp_b = bus.wdata;
    next_rdata = 8'h00;
    if (bus.rd)
    begin
      unique case (bus.addr)
        REG_CLKSET:   next_rdata = {osc_settled, 1'b0, clock_out_enable, startup_time_select, src_sel};
        REG_PRESCALE: next_rdata = {4'h0, ps_sel}; // see [RQ17]
        REG_FTRIM:    next_rdata = trim.fast;
        REG_STRIM:    next_rdata = trim.slow;
        REG_TTRIM_A:  next_rdata = trim.temp_a;
        REG_TTRIM_B:  next_rdata = trim.temp_b;
        REG_FUSE:     next_rdata = {1'b0, fuse.div8, fuse.clock_out, fuse.startup_time,
                                    fuse.source_select}; // see [RQ3]
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  // Register update, fuses and factory trims loaded in reset
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      src_sel          <= fuse.source_select; // see [RQ2]
      sw_code          <= fuse.source_select;
      sw_pend          <= 1'b0;
      startup_time_select              <= fuse.startup_time; // see [RQ8]
      clock_out_enable <= fuse.clock_out; // see [RQ20]
      ps_sel           <= fuse.div8 ? PS_DIV8 : PS_DIV1; // see [RQ14]
      trim             <= factory_trim; // see [RQ9] [RQ11] [RQ12]
      osc_settled      <= 1'b0;
      settle_cnt       <= 16'h0000;
      rdata            <= 8'h00;
    end
    else
    begin
      src_sel          <= next_src_sel;
      sw_code          <= next_sw_code;
      sw_pend          <= next_sw_pend;
      clock_out_enable <= next_clock_out_fuse;
      ps_sel           <= next_ps_sel;
      trim             <= next_trim;
      osc_settled      <= next_settled;
      settle_cnt       <= next_settle_cnt;
      rdata            <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and source multiplexer
  // ----------------------------------------------------------------
  logic [3:0] div_code;
  logic [7:0] edge_cnt;
  logic       div_clk;
  logic [8:0] half_edges;
  logic       act_edge;
  logic [3:0] next_div_code;
  logic [3:0] next_src_active;
  logic [7:0] next_edge_cnt;
  logic       next_div_clk;
  logic       sw_hold;
  logic       next_sw_hold;
  logic       act_fall;

  assign half_edges = 9'h001 << div_code;
  // After a switch, edges count only from the new source's first fall
  assign act_fall   = src_edge[src_index(src_active)] && !src_rise[src_index(src_active)];
  assign act_edge   = src_edge[src_index(src_active)] && !sw_hold; // see [RQ15]
  assign boundary   = act_edge && div_clk && {1'b0, edge_cnt} == half_edges - 9'h001;

  // Count source edges; selections change only at a period end
  always_comb
  begin
    next_div_code   = div_code;
    next_src_active = src_active;
    next_edge_cnt   = edge_cnt;
    next_div_clk    = div_clk;
    next_sw_hold    = sw_hold && !act_fall;
    if (act_edge)
    begin
      if ({1'b0, edge_cnt} == half_edges - 9'h001)
      begin
        next_edge_cnt = 8'h00;
        next_div_clk  = ~div_clk;
      end
      else
        next_edge_cnt = edge_cnt + 8'h01; // see [RQ17]
    end
    if (boundary)
    begin
      next_div_code = ps_sel; // see [RQ16] [RQ18]
      if (sw_pend)
      begin
        next_src_active = sw_code; // see [RQ4]
        next_sw_hold    = 1'b1;
      end
    end
  end

  // Prescaler state
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      div_code   <= fuse.div8 ? PS_DIV8 : PS_DIV1;
      src_active <= fuse.source_select; // see [RQ7]
      edge_cnt   <= 8'h00;
      div_clk    <= 1'b0;
      sw_hold    <= 1'b0;
    end
    else
    begin
      div_code   <= next_div_code;
      src_active <= next_src_active;
      edge_cnt   <= next_edge_cnt;
      div_clk    <= next_div_clk;
      sw_hold    <= next_sw_hold;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  state_e      state;
  state_e      next_state;
  logic [15:0] su_cnt;
  logic [15:0] next_su_cnt;
  logic        act_rise;

  assign act_rise = src_rise[src_index(src_active)];

  // Reset delay on slow ticks, then source cycles; wake on source
  always_comb
  begin
    next_state  = state;
    next_su_cnt = su_cnt;
    unique case (state)
      ST_RST_DLY:
      begin
        if (src_rise[IDX_SLOW])
          next_su_cnt = su_cnt + 16'h0001; // see [RQ6]
        if (su_cnt >= RST_CNT)
        begin
          next_state  = ST_RST_CK;
          next_su_cnt = 16'h0000;
        end
      end
      ST_RST_CK, ST_WAKE:
      begin
        if (act_rise)
          next_su_cnt = su_cnt + 16'h0001;
        if (su_cnt >= startup_ck(startup_time_select, src_active, state == ST_RST_CK)) // see [RQ5] [RQ8]
        begin
          next_state  = ST_RUN;
          next_su_cnt = 16'h0000;
        end
      end
      ST_RUN:
        if (power_down)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (!power_down)
        begin
          next_state  = ST_WAKE;
          next_su_cnt = 16'h0000;
        end
      default:
      begin
        next_state  = ST_RST_DLY;
        next_su_cnt = 16'h0000;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state  <= ST_RST_DLY;
      su_cnt <= 16'h0000;
    end
    else
    begin
      state  <= next_state;
      su_cnt <= next_su_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  logic [3:0] next_osc_en;

  // Slow oscillator kept on outside reset, plus requested and active sources
  always_comb
  begin
    next_osc_en = 4'h0;
    next_osc_en[IDX_SLOW] = 1'b1; // see [RQ13]
    next_osc_en[src_index(src_sel)] = 1'b1;
    next_osc_en[src_index(src_active)] = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      osc_enable       <= 4'h0;
      watchdog_tick    <= 1'b0;
      sys_clk_div      <= 1'b0;
      cpu_run          <= 1'b0;
      clock_out_pin    <= 1'b0; // see [RQ21]
      clock_out_active <= 1'b0;
    end
    else
    begin
      osc_enable       <= next_osc_en;
      watchdog_tick    <= src_rise[IDX_SLOW];
      sys_clk_div      <= div_clk;
      cpu_run          <= state == ST_RUN;
      clock_out_pin    <= div_clk && clock_out_enable; // see [RQ22]
      clock_out_active <= clock_out_enable; // see [RQ19]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_fuse_load_src: assert property ($fell(reset) |-> src_sel == $past(fuse.source_select))
    else $error("source select not loaded from fuse"); // see [RQ2]
  a_trim_load: assert property ($fell(reset) |-> trim == $past(factory_trim))
    else $error("trims not loaded in reset"); // see [RQ9]
  a_trigger_request: assert property (wr_clkset && bus.wdata[TRIGGER_BIT]
      && legal_src(bus.wdata[3:0]) |=> sw_pend && sw_code == $past(bus.wdata[3:0]))
    else $error("trigger write not queued"); // see [RQ24]
  a_src_at_boundary: assert property (!$stable(src_active) |-> $past(boundary))
    else $error("source switched mid period"); // see [RQ4]
  a_div_at_boundary: assert property (!$stable(div_code) |-> $past(boundary))
    else $error("divide changed mid period"); // see [RQ18]
  a_prescale_legal: assert property (ps_sel <= PS_MAX && div_code <= PS_MAX)
    else $error("reserved prescale code held"); // see [RQ26]
  a_clkout_follow: assert property (1'b1 |=> clock_out_pin ==
      ($past(div_clk) && $past(clock_out_enable)))
    else $error("clock output mismatch"); // see [RQ22]
  a_clkout_in_reset: assert property (@(posedge sys_clk) disable iff (1'b0)
      $past(reset) |-> !clock_out_pin)
    else $error("clock driven during reset"); // see [RQ21]
  a_slow_kept_on: assert property ($past(!reset) |-> osc_enable[IDX_SLOW])
    else $error("slow oscillator disabled"); // see [RQ13]
  a_settle_restart: assert property (wr_clkset && legal_src(bus.wdata[3:0])
      |=> settle_cnt == 16'h0000)
    else $error("settle count not restarted"); // see [RQ25]
  a_run_after_wait: assert property ($rose(cpu_run) |-> $past(state == ST_RUN))
    else $error("execution before start-up"); // see [RQ5]

  c_trigger_switch: cover property (sw_pend ##1 !sw_pend);
  c_prescale_change: cover property (!$stable(div_code));
  c_wake_run: cover property (state == ST_WAKE ##1 state == ST_RUN);
  c_settled: cover property ($rose(osc_settled));

endmodule // clock_ctrl

// *** tb/osc_partner.sv ***
// ------
// Source oscillators and external clock
// ------
module osc_partner
(
  input  wire logic       sys_clk,
  input  wire logic [3:0] osc_enable,
  input  wire logic       slow_mode,
  output logic            ext_clock_in,
  output logic            fast_osc_clk,
  output logic            slow_osc_clk,
  output logic            resonator_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] level = 4'h0;
  int         cnt [4] = '{default: 0};

  // Half periods in system cycles; slow mode stretches the fast oscillator
  function automatic int half(input int i);
    if (i == 0)
      return 4;  // Fixed rate, no step changes
    if (i == 1)
      return slow_mode ? 6 : 3;
    if (i == 2)
      return 10;
    return 5;
  endfunction

  // Gated oscillators stop low; external and slow ones run freely
  always @(posedge sys_clk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if ((i == 1 || i == 3) && !osc_enable[i])
      begin
        level[i] <= 1'b0;
        cnt[i]   <= 0;
      end
      else if (cnt[i] >= half(i) - 1)
      begin
        level[i] <= ~level[i];  // Slow one never stops
        cnt[i]   <= 0;
      end
      else
        cnt[i] <= cnt[i] + 1;
    end
  end

  assign ext_clock_in = level[0];
  assign fast_osc_clk = level[1];
  assign slow_osc_clk = level[2];
  assign resonator_in = level[3];
endmodule  // osc_partner

// *** tb/system_clock_source_prescaler_test.sv ***
module system_clock_source_prescaler_test
  import clock_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic [7:0] e; logic [7:0] m; string nm;} note_s;

  logic     sys_clk, reset, power_down, slow_mode, rd_seen;
  bus_req_s bus;
  fuse_s    fuse;
  trim_s    factory_trim, trim, exp_trim;
  logic [7:0] rdata, d;
  logic [3:0] osc_enable;
  logic     watchdog_tick, sys_clk_div, cpu_run, clock_out_pin, clock_out_active;
  logic     ext_c, fast_c, slow_c, res_c;
  int       mismatches, num_checks, hi, n;
  note_s    notes[$];
  note_s    cur;

  clock_ctrl #(.XTAL_CK(8), .RST_TICKS(4)) clock_ctrl_inst (
    .sys_clk(sys_clk), .reset(reset), .bus(bus), .rdata(rdata), .fuse(fuse),
    .factory_trim(factory_trim), .ext_clock_in(ext_c), .fast_osc_clk(fast_c),
    .slow_osc_clk(slow_c), .resonator_in(res_c), .power_down(power_down), .trim(trim),
    .osc_enable(osc_enable), .watchdog_tick(watchdog_tick), .sys_clk_div(sys_clk_div),
    .cpu_run(cpu_run), .clock_out_pin(clock_out_pin), .clock_out_active(clock_out_active));

  osc_partner osc_partner_inst (
    .sys_clk(sys_clk), .osc_enable(osc_enable), .slow_mode(slow_mode),
    .ext_clock_in(ext_c), .fast_osc_clk(fast_c), .slow_osc_clk(slow_c),
    .resonator_in(res_c));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ------
  // Checking
  // ------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task give_up(input string nm);
    mismatches++;
    $display("FAIL %s expected done seen timeout", nm);
    tally_and_finish();
  endtask

  // Read answers compared against the oldest note
  always @(posedge sys_clk)
  begin
    if (rd_seen && notes.size() > 0)
    begin
      cur = notes.pop_front();
      check(cur.nm, {24'h0, rdata & cur.m}, {24'h0, cur.e & cur.m});
    end
    rd_seen <= bus.rd;
  end

  // ------
  // Bus and wait tasks
  // ------
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus.addr  <= a;
    bus.wdata <= v;
    bus.wr    <= 1'b1;
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
    if (m != 8'h00)
      notes.push_back('{e, m, nm});
  endtask

  task wait_run(input logic lvl, input int lim);
    int k;
    k = 0;
    while (cpu_run !== lvl)
    begin
      if (k++ >= lim)
        give_up("cpu_run");
      @(posedge sys_clk);
    end
  endtask

  // High time of the divided clock, third period after the call
  task meas(output int h);
    int k;
    k = 0;
    repeat (3)
    begin
      h = 0;
      while (sys_clk_div !== 1'b0 && k < 9000)
      begin
        @(posedge sys_clk);
        k++;
      end
      while (sys_clk_div !== 1'b1 && k < 9000)
      begin
        @(posedge sys_clk);
        k++;
      end
      while (sys_clk_div === 1'b1 && k < 9000)
      begin
        @(posedge sys_clk);
        k++;
        h++;
      end
    end
    if (k >= 9000)
      give_up("sys_clk_div");
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    void'($urandom(89116));
    reset = 1'b1;
    bus = '0;
    power_down = 1'b0;
    slow_mode = 1'b0;
    rd_seen = 1'b0;
    fuse = '{SRC_FAST, 1'b1, 1'b0, 1'b1};
    factory_trim = $urandom;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check("cpu_run early", cpu_run, 0);
    wait_run(1'b1, 1000);
    rd(REG_CLKSET, 8'h12, 8'h7f, "setting");
    rd(REG_PRESCALE, {4'h0, PS_DIV8}, 8'hff, "prescale");
    for (int i = 0; i < 4; i++)
      rd(REG_FTRIM + 8'(i), factory_trim[31-8*i -: 8], 8'hff, "trim reg");
    check("trim", trim, factory_trim);
    check("clock_out_active", clock_out_active, 0);
    wr(REG_FUSE, 8'h00);
    rd(REG_FUSE, 8'h52, 8'hff, "fuse");
    meas(hi);
    check("div8 high", hi, 24);
    $display("test reset_defaults done");

    exp_trim = factory_trim;
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      exp_trim[31-8*i -: 8] = d;
      wr(REG_FTRIM + 8'(i), d);
      rd(REG_FTRIM + 8'(i), d, 8'hff, "trim write");
    end
    check("trim out", trim, exp_trim);
    $display("test trim done");

    wr(REG_CLKSET, 8'h22);
    for (int c = 0; c <= 8; c++)
    begin
      wr(REG_PRESCALE, 8'(c));
      meas(hi);
      check("divide high", hi, 3 << c);
    end
    wr(REG_PRESCALE, 8'h09);
    rd(REG_PRESCALE, 8'h08, 8'hff, "reserved prescale");
    wr(REG_PRESCALE, 8'h00);
    meas(hi);
    check("div1 back", hi, 3);
    n = 0;
    repeat (30)
    begin
      @(posedge sys_clk);
      n += (clock_out_pin !== sys_clk_div);
    end
    check("pin follows clock", n, 0);
    wr(REG_CLKSET, 8'h02);
    @(posedge sys_clk);  // Pin lags the enable by one cycle
    n = 0;
    repeat (30)
    begin
      @(posedge sys_clk);
      n += (clock_out_pin !== 1'b0);
    end
    check("pin off", n, 0);
    $display("test prescale done");

    wr(REG_CLKSET, 8'h00);
    rd(REG_CLKSET, 8'h00, 8'h80, "settled clear");
    repeat (4) @(posedge sys_clk);
    check("ext enabled", osc_enable[IDX_EXT], 1);
    meas(hi);
    check("not switched", hi, 3);
    n = 0;
    d = 8'h00;
    while (d[SETTLED_BIT] !== 1'b1)
    begin
      if (n++ > 60)
        give_up("settled");
      rd(REG_CLKSET, 8'h00, 8'h00, "");
    end
    wr(REG_CLKSET, 8'h40);
    meas(hi);
    check("ext high", hi, 4);
    wr(REG_CLKSET, 8'h41);
    rd(REG_CLKSET, 8'h10, 8'h7f, "reserved source");
    wr(REG_CLKSET, 8'h08);
    repeat (4) @(posedge sys_clk);
    check("resonator enabled", osc_enable[IDX_RES], 1);
    wr(REG_CLKSET, 8'h44);
    meas(hi);
    check("slow high", hi, 10);
    n = 0;
    repeat (40)
    begin
      @(posedge sys_clk);
      n += (watchdog_tick === 1'b1);
    end
    check("watchdog ticks", n, 2);
    wr(REG_CLKSET, 8'h42);
    $display("test source done");

    slow_mode <= 1'b1;
    power_down <= 1'b1;
    wait_run(1'b0, 20);
    power_down <= 1'b0;
    repeat (50) @(posedge sys_clk);
    check("wake early", cpu_run, 0);
    wait_run(1'b1, 400);
    slow_mode <= 1'b0;
    $display("test power_down done");

    fuse <= '{SRC_EXT, 1'b0, 1'b1, 1'b0};
    reset <= 1'b1;
    n = 0;
    repeat (20)
    begin
      @(posedge sys_clk);
      n += (clock_out_pin !== 1'b0);
    end
    check("pin in reset", n, 0);
    reset <= 1'b0;
    wait_run(1'b1, 1000);
    check("clock_out_active", clock_out_active, 1);
    rd(REG_CLKSET, 8'h20, 8'h7f, "setting 2");
    rd(REG_PRESCALE, 8'h00, 8'hff, "prescale 2");
    meas(hi);
    check("ext div1 high", hi, 4);
    $display("test second_reset done");
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule  // system_clock_source_prescaler_test
